/* File: logic/dfp_unit.sv */
// Fixed-point signal-processing datapath with accumulators and flags.
`default_nettype none
module dfp_unit (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire dfp_pkg::dfp_req_t req,
    output logic resultValid,
    output logic [31:0] result,
    output logic [31:0] ctlStatus
);
    // ************************************************************
    // State
    // ************************************************************
    logic [31:0] ctl_reg;
    logic [31:0] ctl_next;
    logic [63:0] acc_reg [dfp_pkg::ACC_N];
    logic [63:0] acc_next [dfp_pkg::ACC_N];
    logic [31:0] result_reg;
    logic [31:0] result_next;
    logic valid_reg;
    logic [7:0] ouSet;

    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] accSelVal;
    assign a = req.srcA;
    assign b = req.srcB;
    assign accSelVal = acc_reg[req.accSel];

    // ************************************************************
    // SIMD lanes
    // ************************************************************
    logic [31:0] phY;
    logic [1:0] phOvf;
    logic [1:0] phCmp;
    logic [31:0] shlY;
    logic [1:0] shlOvf;
    logic [31:0] qbY;
    logic [3:0] qbOvf;
    logic [3:0] qbCmp;
    logic [31:0] wY;
    logic wOvf;

    genvar g;
    generate
        for (g = 0; g < 2; g++) begin : gPh
            logic [15:0] ha;
            logic [15:0] hb;
            logic [31:0] wide;
            assign ha = a[16*g +: 16];
            assign hb = b[16*g +: 16];
            dfp_lane_addsub #(.W(16)) uLane (
                .a(ha),
                .b(hb),
                .sub(req.op == dfp_pkg::OP_SUB_PH),
                .isSigned(1'b1),
                .sat(req.sat),
                .y(phY[16*g +: 16]),
                .ovf(phOvf[g])
            );
            assign phCmp[g] = (req.cmp == dfp_pkg::CMP_EQ) ? (ha == hb) :
                (req.cmp == dfp_pkg::CMP_LT) ? ($signed(ha) < $signed(hb)) :
                ($signed(ha) <= $signed(hb));
            assign wide = {{16{ha[15]}}, ha} << req.amount[3:0];
            assign shlOvf[g] = wide[31:15] != {17{wide[15]}};
            assign shlY[16*g +: 16] = (shlOvf[g] && req.sat) ?
                (ha[15] ? dfp_pkg::Q15_MIN : dfp_pkg::Q15_MAX) :
                wide[15:0];
        end
        for (g = 0; g < 4; g++) begin : gQb
            logic [7:0] ba;
            logic [7:0] bb;
            assign ba = a[8*g +: 8];
            assign bb = b[8*g +: 8];
            dfp_lane_addsub #(.W(8)) uLane (
                .a(ba),
                .b(bb),
                .sub(req.op == dfp_pkg::OP_SUB_QB),
                .isSigned(1'b0),
                .sat(req.sat),
                .y(qbY[8*g +: 8]),
                .ovf(qbOvf[g])
            );
            assign qbCmp[g] = (req.cmp == dfp_pkg::CMP_EQ) ? (ba == bb) :
                (req.cmp == dfp_pkg::CMP_LT) ? (ba < bb) :
                (ba <= bb);
        end
    endgenerate

    dfp_lane_addsub #(.W(32)) uWord (
        .a(a),
        .b(b),
        .sub(req.op == dfp_pkg::OP_SUB_W),
        .isSigned(1'b1),
        .sat(req.sat),
        .y(wY),
        .ovf(wOvf)
    );

    // ************************************************************
    // Fractional multiply, rounding, extract
    // ************************************************************
    logic signed [31:0] mulP;
    logic mulOvf;
    logic [31:0] mulY;
    assign mulP = $signed(a[15:0]) * $signed(b[15:0]);
    assign mulOvf = (a[15:0] == dfp_pkg::Q15_MIN) &&
        (b[15:0] == dfp_pkg::Q15_MIN);
    // Only -1 times -1 cannot be held after the doubling shift.
    assign mulY = mulOvf ? dfp_pkg::Q31_MAX : {mulP[30:0], 1'b0};

    logic signed [63:0] macP;
    logic macProdOvf;
    logic [63:0] macProd;
    logic [64:0] macSum;
    logic macAccOvf;
    logic [63:0] macY;
    assign macP = $signed(a) * $signed(b);
    assign macProdOvf = (a == dfp_pkg::Q31_MIN) && (b == dfp_pkg::Q31_MIN);
    assign macProd = macProdOvf ? dfp_pkg::Q63_MAX :
        {macP[62:0], 1'b0};
    assign macSum = {accSelVal[63], accSelVal} + {macProd[63], macProd};
    assign macAccOvf = macSum[64] ^ macSum[63];
    assign macY = (macAccOvf && req.sat) ?
        (macSum[64] ? dfp_pkg::Q63_MIN : dfp_pkg::Q63_MAX) :
        macSum[63:0];

    logic [31:0] shraTrunc;
    logic [31:0] shraDisc;
    logic [31:0] shraHalf;
    logic [31:0] shraY;
    assign shraTrunc = $signed(a) >>> req.amount[4:0];
    assign shraDisc = a & ((32'h1 << req.amount[4:0]) - 32'h1);
    assign shraHalf = (32'h1 << req.amount[4:0]) >> 1;
    assign shraY = shraTrunc + {31'h0, shraDisc > shraHalf};

    function automatic logic [16:0] precRound(input logic [31:0] x);
        logic up;
        logic o;
        up = x[15:0] > 16'h8000;
        o = up && (x[31:16] == dfp_pkg::Q15_MAX);
        precRound = {o, o ? dfp_pkg::Q15_MAX : x[31:16] + {15'h0, up}};
    endfunction
    logic [16:0] precA;
    logic [16:0] precB;
    assign precA = precRound(a);
    assign precB = precRound(b);

    logic [5:0] pos;
    logic extFail;
    logic [63:0] extWide;
    logic [32:0] extMask;
    logic [31:0] extY;
    assign pos = ctl_reg[dfp_pkg::CTL_POS_LSB +: dfp_pkg::CTL_POS_W];
    assign extFail = pos < {1'b0, req.amount[4:0]};
    assign extWide = accSelVal >> (pos - {1'b0, req.amount[4:0]});
    assign extMask = (33'h1 << ({1'b0, req.amount[4:0]} + 6'h1)) - 33'h1;
    assign extY = extFail ? 32'h0 : extWide[31:0] & extMask[31:0];

    logic [63:0] shiloY;
    assign shiloY = req.amount[5] ? accSelVal << (6'h0 - req.amount) :
        accSelVal >> req.amount;

    logic [32:0] addscSum;
    assign addscSum = {1'b0, a} + {1'b0, b};

    // ************************************************************
    // Next state
    // ************************************************************
    always_comb begin
        ctl_next = ctl_reg;
        acc_next = acc_reg;
        result_next = result_reg;
        ouSet = 8'h00;
        if (reqValid) begin
            unique case (req.op)
                dfp_pkg::OP_RDCTL: begin
                    result_next = ctl_reg;
                end
                dfp_pkg::OP_WRCTL: begin
                    ctl_next = a & dfp_pkg::CTL_WMASK;
                end
                dfp_pkg::OP_ADD_W, dfp_pkg::OP_SUB_W: begin
                    result_next = wY;
                    ouSet[dfp_pkg::OU_ADDSUB] = wOvf;
                end
                dfp_pkg::OP_ADD_PH, dfp_pkg::OP_SUB_PH: begin
                    result_next = phY;
                    ouSet[dfp_pkg::OU_ADDSUB] = |phOvf;
                end
                dfp_pkg::OP_ADD_QB, dfp_pkg::OP_SUB_QB: begin
                    result_next = qbY;
                    ouSet[dfp_pkg::OU_ADDSUB] = |qbOvf;
                end
                dfp_pkg::OP_CMP_PH: begin
                    ctl_next[dfp_pkg::CTL_CCOND_LSB +: 2] = phCmp;
                end
                dfp_pkg::OP_CMP_QB: begin
                    ctl_next[dfp_pkg::CTL_CCOND_LSB +: 4] = qbCmp;
                end
                dfp_pkg::OP_ADDSC: begin
                    result_next = addscSum[31:0];
                    ctl_next[dfp_pkg::CTL_CARRY_BIT] = addscSum[32];
                end
                dfp_pkg::OP_ADDWC: begin
                    result_next = a + b +
                        {31'h0, ctl_reg[dfp_pkg::CTL_CARRY_BIT]};
                end
                dfp_pkg::OP_MULQ_PH: begin
                    result_next = mulY;
                    ouSet[dfp_pkg::OU_MUL] = mulOvf;
                end
                dfp_pkg::OP_MAQ_W: begin
                    acc_next[req.accSel] = macY;
                    ouSet[dfp_pkg::OU_MUL] = macProdOvf;
                    ouSet[req.accSel] = macAccOvf;
                end
                dfp_pkg::OP_SHLL_PH: begin
                    result_next = shlY;
                    ouSet[dfp_pkg::OU_SHLCONV] = |shlOvf;
                end
                dfp_pkg::OP_SHRA_R_W: begin
                    result_next = shraY;
                end
                dfp_pkg::OP_PRECRQ_R: begin
                    result_next = {precA[15:0], precB[15:0]};
                    ouSet[dfp_pkg::OU_SHLCONV] = precA[16] | precB[16];
                end
                dfp_pkg::OP_EXTP: begin
                    result_next = extY;
                    ctl_next[dfp_pkg::CTL_EFI_BIT] = extFail;
                end
                dfp_pkg::OP_MTHLIP: begin
                    acc_next[req.accSel] = {accSelVal[31:0], a};
                    ctl_next[dfp_pkg::CTL_POS_LSB +: dfp_pkg::CTL_POS_W] =
                        pos + dfp_pkg::MTHLIP_STEP;
                end
                dfp_pkg::OP_SHILO: begin
                    acc_next[req.accSel] = shiloY;
                end
                dfp_pkg::OP_MFHI: begin
                    result_next = accSelVal[63:32];
                end
                dfp_pkg::OP_MFLO: begin
                    result_next = accSelVal[31:0];
                end
                dfp_pkg::OP_MTHI: begin
                    acc_next[req.accSel][63:32] = a;
                end
                dfp_pkg::OP_MTLO: begin
                    acc_next[req.accSel][31:0] = a;
                end
                default: begin
                end
            endcase
        end
        ctl_next[dfp_pkg::CTL_OU_LSB +: dfp_pkg::CTL_OU_W] =
            ctl_next[dfp_pkg::CTL_OU_LSB +: dfp_pkg::CTL_OU_W] | ouSet;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctl_reg <= dfp_pkg::CTL_RESET;
            for (int i = 0; i < dfp_pkg::ACC_N; i++) begin
                acc_reg[i] <= 64'h0;
            end
            result_reg <= 32'h0;
            valid_reg <= 1'b0;
        end else begin
            ctl_reg <= ctl_next;
            acc_reg <= acc_next;
            result_reg <= result_next;
            valid_reg <= reqValid;
        end
    end

    assign result = result_reg;
    assign resultValid = valid_reg;
    assign ctlStatus = ctl_reg;
endmodule
`default_nettype wire

/* File: logic/dfp_pkg.sv */
// Constants, opcodes and request carrier for the fixed-point flag unit.
`default_nettype none
package dfp_pkg;

    // ************************************************************
    // Control and status register layout
    // ************************************************************
    localparam int CTL_POS_LSB = 0;
    localparam int CTL_POS_W = 6;
    localparam int CTL_SCOUNT_LSB = 7;
    localparam int CTL_SCOUNT_W = 6;
    localparam int CTL_CARRY_BIT = 13;
    localparam int CTL_EFI_BIT = 14;
    localparam int CTL_OU_LSB = 16;
    localparam int CTL_OU_W = 8;
    localparam int OU_ADDSUB = 4;
    localparam int OU_MUL = 5;
    localparam int OU_SHLCONV = 6;
    localparam int CTL_CCOND_LSB = 24;
    localparam int CTL_CCOND_W = 4;
    localparam logic [31:0] CTL_RESET = 32'h0000_0000;
    localparam logic [31:0] CTL_WMASK = 32'h0FFF_7FBF;

    // ************************************************************
    // Datapath constants
    // ************************************************************
    localparam int ACC_N = 4;
    localparam int ACC_W = 64;
    localparam logic [5:0] MTHLIP_STEP = 6'h20;
    localparam logic [15:0] Q15_MAX = 16'h7FFF;
    localparam logic [15:0] Q15_MIN = 16'h8000;
    localparam logic [31:0] Q31_MAX = 32'h7FFF_FFFF;
    localparam logic [31:0] Q31_MIN = 32'h8000_0000;
    localparam logic [63:0] Q63_MAX = 64'h7FFF_FFFF_FFFF_FFFF;
    localparam logic [63:0] Q63_MIN = 64'h8000_0000_0000_0000;

    // ************************************************************
    // Operations
    // ************************************************************
    typedef enum logic [4:0] {
        OP_NOP = 5'h00,
        OP_RDCTL = 5'h01,
        OP_WRCTL = 5'h02,
        OP_ADD_W = 5'h03,
        OP_SUB_W = 5'h04,
        OP_ADD_PH = 5'h05,
        OP_SUB_PH = 5'h06,
        OP_ADD_QB = 5'h07,
        OP_SUB_QB = 5'h08,
        OP_CMP_PH = 5'h09,
        OP_CMP_QB = 5'h0A,
        OP_ADDSC = 5'h0B,
        OP_ADDWC = 5'h0C,
        OP_MULQ_PH = 5'h0D,
        OP_MAQ_W = 5'h0E,
        OP_SHLL_PH = 5'h0F,
        OP_SHRA_R_W = 5'h10,
        OP_PRECRQ_R = 5'h11,
        OP_EXTP = 5'h12,
        OP_MTHLIP = 5'h13,
        OP_SHILO = 5'h14,
        OP_MFHI = 5'h15,
        OP_MFLO = 5'h16,
        OP_MTHI = 5'h17,
        OP_MTLO = 5'h18
    } dfp_op_t;

    typedef enum logic [1:0] {
        CMP_EQ = 2'h0,
        CMP_LT = 2'h1,
        CMP_LE = 2'h2
    } dfp_cmp_t;

    typedef struct packed {
        dfp_op_t op;
        logic [31:0] srcA;
        logic [31:0] srcB;
        logic [1:0] accSel;
        logic sat;
        dfp_cmp_t cmp;
        logic [5:0] amount;
    } dfp_req_t;

endpackage
`default_nettype wire

/* File: logic/dfp_lane_addsub.sv */
// One SIMD lane adder/subtractor with optional saturation.
`default_nettype none
module dfp_lane_addsub #(
    parameter int W = 8
) (
    input wire logic [W-1:0] a,
    input wire logic [W-1:0] b,
    input wire logic sub,
    input wire logic isSigned,
    input wire logic sat,
    output logic [W-1:0] y,
    output logic ovf
);
    logic [W:0] ax;
    logic [W:0] bx;
    logic [W:0] s;
    logic [W-1:0] limit;

    assign ax = {isSigned & a[W-1], a};
    assign bx = {isSigned & b[W-1], b};
    assign s = sub ? ax - bx : ax + bx;
    assign ovf = isSigned ? (s[W] ^ s[W-1]) : s[W];
    // Signed lanes clamp by sign; unsigned ones to zero or all ones.
    always_comb begin
        if (isSigned) begin
            limit = s[W] ? {1'b1, {(W-1){1'b0}}} : {1'b0, {(W-1){1'b1}}};
        end else begin
            limit = sub ? {W{1'b0}} : {W{1'b1}};
        end
    end
    assign y = (ovf && sat) ? limit : s[W-1:0];
endmodule
`default_nettype wire

/* File: test/dfp_unit_monitor.sv */
// Checker of the fixed-point flag unit's port behaviour.
`default_nettype none
module dfp_unit_monitor (
    input wire logic clk,
    input wire logic rst,
    input wire logic reqValid,
    input wire dfp_pkg::dfp_req_t req,
    input wire logic resultValid,
    input wire logic [31:0] result,
    input wire logic [31:0] ctlStatus
);
    timeunit 1ns;
    timeprecision 100ps;
    // **********
    // Properties
    // **********
    default clocking @(posedge clk); endclocking
    default disable iff (rst);
    sequence opIs(dfp_pkg::dfp_op_t o);
        reqValid && req.op == o;
    endsequence
    sequence ouKept;
        ctlStatus[23:16] == $past(ctlStatus[23:16]);
    endsequence
    answer_pulse_a: assert property (reqValid |=> resultValid)
        else $error("no answer pulse");
    idle_quiet_a: assert property (!reqValid |=> !resultValid
        && $stable(ctlStatus)) else $error("change while idle");
    spare_zero_a: assert property (
        (ctlStatus & ~dfp_pkg::CTL_WMASK) == 32'h0)
        else $error("spare bit set");
    ctl_read_a: assert property (opIs(dfp_pkg::OP_RDCTL)
        |=> result == $past(ctlStatus)) else $error("read value");
    ctl_write_a: assert property (opIs(dfp_pkg::OP_WRCTL)
        |=> ctlStatus == ($past(req.srcA) & dfp_pkg::CTL_WMASK))
        else $error("write value");
    ccond_upper_a: assert property (opIs(dfp_pkg::OP_CMP_PH)
        |=> ctlStatus[27:26] == $past(ctlStatus[27:26]))
        else $error("upper condition bits");
    flag_quiet_a: assert property (reqValid && req.op inside
        {dfp_pkg::OP_ADDSC, dfp_pkg::OP_ADDWC, dfp_pkg::OP_SHILO}
        |=> ouKept) else $error("flag from carry add or shift");
    flag_sticky_a: assert property (reqValid
        && req.op != dfp_pkg::OP_WRCTL |=> (ctlStatus[23:16]
        & $past(ctlStatus[23:16])) == $past(ctlStatus[23:16]))
        else $error("flag lost");
    pos_step_a: assert property (opIs(dfp_pkg::OP_MTHLIP) |=>
        ctlStatus[5:0] == $past(ctlStatus[5:0]) + dfp_pkg::MTHLIP_STEP)
        else $error("position step");
    extract_fail_a: assert property (opIs(dfp_pkg::OP_EXTP) |=>
        ctlStatus[14] == ($past(ctlStatus[5:0]) < $past(req.amount[4:0])))
        else $error("extract fail flag");
    carry_hold_a: assert property (opIs(dfp_pkg::OP_ADDWC) |=>
        $stable(ctlStatus[13])) else $error("carry changed");
endmodule
bind dfp_unit dfp_unit_monitor dfp_unit_monitor_i (.clk(clk), .rst(rst),
    .reqValid(reqValid), .req(req), .resultValid(resultValid),
    .result(result), .ctlStatus(ctlStatus));
`default_nettype wire

/* File: test/dfp_pipe_model.sv */
// Pipeline model that issues instructions to the unit.
`default_nettype none
module dfp_pipe_model (
    input wire logic clk,
    input wire logic resultValid,
    input wire logic [31:0] result,
    output logic reqValid,
    output var dfp_pkg::dfp_req_t req
);
    timeunit 1ns;
    timeprecision 100ps;
    int seed = 43847;
    initial begin
        reqValid = 1'b0;
        req = '0;
    end
    // ***********
    // Issue tasks
    // ***********
    // A random stall cycle with garbage on the request mimics a slow pipe.
    task automatic issue(dfp_pkg::dfp_req_t r, output logic v,
        output logic [31:0] res);
        if ($random(seed) % 4 == 0) begin
            reqValid = 1'b0;
            req = ~r;
            @(posedge clk);
            #1;
        end
        reqValid = 1'b1;
        req = r;
        @(posedge clk);
        #1;
        v = resultValid;
        res = result;
    endtask
    task automatic idle();
        reqValid = 1'b0;
        @(posedge clk);
        #1;
    endtask
endmodule
`default_nettype wire

/* File: test/dfp_unit_test.sv */
// Self-checking bench for the fixed-point flag unit.
`default_nettype none
`define CHK(n, e, g) begin checksDone++; if ((g) !== (e)) begin errors++; \
    $display("MISMATCH %s exp %h got %h", n, e, g); end end
module dfp_unit_test;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk, rst, reqValid, resultValid, f;
    dfp_pkg::dfp_req_t req;
    logic [31:0] result, ctlStatus, res, a, b, u;
    logic [16:0] ra, rb;
    logic [63:0] w;
    int seed = 43847;
    int errors = 0;
    int checksDone = 0;
    int p, s;
    dfp_unit dfp_unit_i (.clk(clk), .rst(rst), .reqValid(reqValid),
        .req(req), .resultValid(resultValid), .result(result),
        .ctlStatus(ctlStatus));
    dfp_pipe_model dfp_pipe_model_i (.clk(clk), .resultValid(resultValid),
        .result(result), .reqValid(reqValid), .req(req));
    // *******************
    // Reference functions
    // *******************
    function automatic logic [32:0] qbRef(logic [31:0] x, y, logic sb, st);
        logic [8:0] t;
        qbRef = '0;
        for (int k = 0; k < 4; k++) begin
            t = sb ? x[8*k+:8] - y[8*k+:8] : x[8*k+:8] + y[8*k+:8];
            qbRef[32] |= t[8];
            qbRef[8*k+:8] = t[8] && st ? {8{~sb}} : t[7:0];
        end
    endfunction
    function automatic logic [31:0] cmpRef(logic [31:0] x, y, int c, logic q);
        logic signed [16:0] m, n;
        cmpRef = 32'h0;
        for (int k = 0; k < 4; k++) begin
            if (q || k < 2) begin
                m = q ? 17'(x[8*k+:8]) : 17'($signed(x[16*k+:16]));
                n = q ? 17'(y[8*k+:8]) : 17'($signed(y[16*k+:16]));
                cmpRef[k] = c == 0 ? m == n : c == 1 ? m < n : m <= n;
            end
        end
    endfunction
    function automatic logic [31:0] shraRef(logic [31:0] x, int n);
        shraRef = $signed(x) >>> n;
        if ((x & ((32'h1 << n) - 1)) > (32'h1 << (n - 1))) shraRef += 1;
    endfunction
    function automatic logic [32:0] wordRef(logic [31:0] x, y, logic sb, st);
        logic [32:0] t;
        t = sb ? {x[31], x} - {y[31], y} : {x[31], x} + {y[31], y};
        wordRef = {t[32] ^ t[31], t[31:0]};
        if (wordRef[32] && st) begin
            wordRef[31:0] = t[32] ? dfp_pkg::Q31_MIN : dfp_pkg::Q31_MAX;
        end
    endfunction
    function automatic logic [16:0] rndRef(logic [31:0] x);
        int t;
        t = $signed(x[31:16]) + (x[15:0] > 16'h8000 ? 1 : 0);
        rndRef = t > 32767 ? {1'b1, dfp_pkg::Q15_MAX} : {1'b0, 16'(t)};
    endfunction
    // *************
    // Test sequence
    // *************
    task automatic run(dfp_pkg::dfp_op_t op, logic [31:0] x, y,
        logic [1:0] sel = 2'h0, logic st = 1'b0, logic [5:0] amt = 6'h0,
        logic [1:0] cm = 2'h0);
        dfp_pkg::dfp_req_t r;
        logic v;
        r = '{op, x, y, sel, st, dfp_pkg::dfp_cmp_t'(cm), amt};
        dfp_pipe_model_i.issue(r, v, res);
        `CHK("resultValid", 1'b1, v)
    endtask
    task automatic test_done();
        $display("checks %0d errors %0d", checksDone, errors);
        if (errors == 0 && checksDone > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    // The sequence needs about 400 cycles; this span leaves ample margin.
    initial begin
        #100000;
        errors++;
        test_done();
    end
    initial begin
        rst = 1'b1;
        repeat (10) @(posedge clk);
        `CHK("resetCtl", 32'h0, ctlStatus)
        #1;
        rst = 1'b0;
        for (int i = 0; i < 4; i++) begin
            a = i == 0 ? 32'hFFFF_FFFF : $random(seed);
            run(dfp_pkg::OP_WRCTL, a, 32'h0);
            run(dfp_pkg::OP_RDCTL, 32'h0, 32'h0);
            `CHK("ctlRead", a & dfp_pkg::CTL_WMASK, res)
        end
        run(dfp_pkg::dfp_op_t'(5'h1F), 32'h0, 32'h0);
        `CHK("refused", a & dfp_pkg::CTL_WMASK, ctlStatus)
        run(dfp_pkg::OP_NOP, 32'hFFFF_FFFF, 32'hFFFF_FFFF);
        `CHK("noOp", a & dfp_pkg::CTL_WMASK, ctlStatus)
        run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
        run(dfp_pkg::OP_ADD_PH, 32'h7FFF_0001, 32'h0001_0001, 2'h0, 1'b1);
        `CHK("halfAdd", 32'h7FFF_0002, res)
        `CHK("addFlag", 1'b1, ctlStatus[20])
        run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
        run(dfp_pkg::OP_SUB_PH, 32'h8000_0005, 32'h0001_0007, 2'h0, 1'b1);
        `CHK("halfSub", 32'h8000_FFFE, res)
        `CHK("subFlag", 1'b1, ctlStatus[20])
        for (int i = 0; i < 12; i++) begin
            a = i == 0 ? dfp_pkg::Q31_MAX : i == 1 ? dfp_pkg::Q31_MIN :
                $random(seed);
            b = i < 2 ? 32'h1 : $random(seed);
            p = i < 2 ? i + 2 : $random(seed) & 3;
            run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
            run(p[0] ? dfp_pkg::OP_SUB_W : dfp_pkg::OP_ADD_W, a, b, 2'h0,
                p[1]);
            {f, u} = wordRef(a, b, p[0], p[1]);
            `CHK("wordOp", u, res)
            `CHK("wordFlag", f, ctlStatus[20])
        end
        for (int i = 0; i < 40; i++) begin
            a = $random(seed);
            b = $random(seed);
            p = $random(seed) & 3;
            run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
            run(p[0] ? dfp_pkg::OP_SUB_QB : dfp_pkg::OP_ADD_QB, a, b, 2'h0,
                p[1]);
            {f, u} = qbRef(a, b, p[0], p[1]);
            `CHK("byteOp", u, res)
            `CHK("byteFlag", f, ctlStatus[20])
        end
        for (int i = 0; i < 18; i++) begin
            a = $random(seed);
            b = i % 3 == 0 ? a : $random(seed);
            f = (i / 3) % 2 == 1;
            run(dfp_pkg::OP_WRCTL, 32'h0F00_0000, 32'h0);
            run(f ? dfp_pkg::OP_CMP_QB : dfp_pkg::OP_CMP_PH, a, b, 2'h0, 1'b0,
                6'h0, 2'(i % 3));
            u = cmpRef(a, b, i % 3, f);
            u[3:2] = f ? u[3:2] : 2'b11;
            `CHK("ccond", u[3:0], ctlStatus[27:24])
        end
        run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
        for (int i = 0; i < 10; i++) begin
            a = i == 0 ? 32'h8000 : $random(seed);
            b = i == 0 ? 32'h8000 : $random(seed);
            run(dfp_pkg::OP_MULQ_PH, a, b);
            u = $signed(a[15:0]) * $signed(b[15:0]);
            u = i == 0 ? dfp_pkg::Q31_MAX : u << 1;
            `CHK("fracMul", u, res)
            if (i == 0) `CHK("mulFlag", 1'b1, ctlStatus[21])
        end
        for (int i = 0; i < 12; i++) begin
            a = i == 0 ? 32'h6 : $random(seed);
            p = i == 0 ? 2 : {$random(seed)} % 31 + 1;
            run(dfp_pkg::OP_SHRA_R_W, a, 32'h0, 2'h0, 1'b0, 6'(p));
            `CHK("roundShift", shraRef(a, p), res)
        end
        for (int i = 0; i < 4; i++) begin
            run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
            run(dfp_pkg::OP_MTHI, 32'h7FFF_FFFF, 32'h0, 2'(i));
            run(dfp_pkg::OP_MTLO, 32'hFFFF_FFFF, 32'h0, 2'(i));
            run(dfp_pkg::OP_MAQ_W, 32'h4000_0000, 32'h4000_0000, 2'(i), i[0]);
            `CHK("accFlag", 4'h1 << i, ctlStatus[19:16])
        end
        for (int i = 0; i < 4; i++) begin
            run(dfp_pkg::OP_MFHI, 32'h0, 32'h0, 2'(i));
            `CHK("accHigh", i[0] ? 32'h7FFF_FFFF : 32'h9FFF_FFFF, res)
        end
        for (int i = 0; i < 8; i++) begin
            a = $random(seed);
            u = $random(seed);
            p = {$random(seed)} % 64;
            s = {$random(seed)} % 32;
            run(dfp_pkg::OP_WRCTL, 32'(p), 32'h0);
            run(dfp_pkg::OP_MTLO, u, 32'h0, 2'(i));
            run(dfp_pkg::OP_MTHLIP, a, 32'h0, 2'(i));
            p = (p + 32) % 64;
            `CHK("pos", 6'(p), ctlStatus[5:0])
            run(dfp_pkg::OP_EXTP, 32'h0, 32'h0, 2'(i), 1'b0, 6'(s));
            b = p < s ? 32'h0 : 32'(({u, a} >> (p - s)) & ((64'h2 << s) - 1));
            `CHK("extractFail", p < s, ctlStatus[14])
            `CHK("extract", b, res)
            run(dfp_pkg::OP_MFHI, 32'h0, 32'h0, 2'(i));
            `CHK("highCopy", u, res)
        end
        for (int i = 0; i < 6; i++) begin
            a = i == 0 ? 32'hFFFF_FFFF : $random(seed);
            b = i == 0 ? 32'h1 : $random(seed);
            run(dfp_pkg::OP_ADDSC, a, b);
            {f, u} = {1'b0, a} + b;
            `CHK("carryAdd", u, res)
            `CHK("carry", f, ctlStatus[13])
            run(dfp_pkg::OP_ADDWC, b, a);
            `CHK("chainAdd", u + 32'(f), res)
        end
        run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
        run(dfp_pkg::OP_SHLL_PH, 32'h4000_0001, 32'h0, 2'h0, 1'b1, 6'h1);
        `CHK("shiftLeft", 32'h7FFF_0002, res)
        `CHK("shiftFlag", 1'b1, ctlStatus[22])
        for (int i = 0; i < 8; i++) begin
            a = i == 0 ? 32'h7FFF_8001 : $random(seed);
            b = i == 0 ? 32'h1234_8000 : $random(seed);
            ra = rndRef(a);
            rb = rndRef(b);
            run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
            run(dfp_pkg::OP_PRECRQ_R, a, b);
            `CHK("narrow", {ra[15:0], rb[15:0]}, res)
            `CHK("narrowFlag", ra[16] | rb[16], ctlStatus[22])
        end
        for (int i = 0; i < 6; i++) begin
            a = $random(seed);
            b = $random(seed);
            p = i == 0 ? 63 : {$random(seed)} % 64;
            w = {a, b};
            w = p > 31 ? w << (64 - p) : w >> p;
            run(dfp_pkg::OP_WRCTL, 32'h0, 32'h0);
            run(dfp_pkg::OP_MTHI, a, 32'h0, 2'(i));
            run(dfp_pkg::OP_MTLO, b, 32'h0, 2'(i));
            run(dfp_pkg::OP_SHILO, 32'h0, 32'h0, 2'(i), 1'b0, 6'(p));
            `CHK("accShiftFlags", 8'h00, ctlStatus[23:16])
            run(dfp_pkg::OP_MFHI, 32'h0, 32'h0, 2'(i));
            `CHK("accShiftHigh", w[63:32], res)
            run(dfp_pkg::OP_MFLO, 32'h0, 32'h0, 2'(i));
            `CHK("accShiftLow", w[31:0], res)
        end
        dfp_pipe_model_i.idle();
        test_done();
    end
endmodule
`default_nettype wire
